// file: pkg/iaxc_regs.vh
// constants for the indexed axis command executor
`ifndef IAXC_REGS_VH
`define IAXC_REGS_VH
`define IAXC_OP_SOFT_STOP 8'h36
`define IAXC_OP_PARAM_WRITE 8'h10
`define IAXC_OP_PARAM_READ 8'h11
`define IAXC_OP_ACCU_TO_PARAM 8'h12
`define IAXC_OP_VAR_STORE 8'h37
`define IAXC_OP_VAR_LOAD 8'h38
`define IAXC_OP_VAR_FROM_ACCU 8'h39
`define IAXC_ST_OK 8'h64
`define IAXC_ST_BAD_CSUM 8'h01
`define IAXC_ST_BAD_CMD 8'h02
`define IAXC_ST_BAD_VALUE 8'h04
`define IAXC_PARAM_TARGET_SPEED 8'h02
`define IAXC_PARAM_VEL_MODE 8'hff
`define IAXC_FRAME_LEN 4'h9
`define IAXC_VAR_MAX 32'h000000ff
`endif

// file: hw/iaxc_exec.v
// indexed axis command executor: frame receiver, executor, reply sender
// Summary of operation
// - opcode 54 soft-stops the axis chosen by the index register
// - soft stop selects velocity mode then writes zero target speed
// - opcode 16 writes frame value to type-numbered parameter of indexed axis
// - opcode 17 loads accumulator from type-numbered parameter of indexed axis
// - indexed parameter read replies status 100 with the value read
// - opcode 18 copies accumulator into parameter of indexed axis, value ignored
// - store-indexed-variable writes frame value to user variable at index
// - indexed variable store and load do nothing when index outside 0..255
// - load-indexed-variable copies indexed user variable into accumulator
// - indexed variable store ignores type and motor/bank fields
`timescale 1ns/10ps
`default_nettype none
`include "iaxc_regs.vh"
module iaxc_exec #(
    parameter NUM_VARS = 256,
    parameter [7:0] MODULE_ADDR = 8'h01,
    parameter [7:0] HOST_ADDR = 8'h02
) (
    input wire sys_clk_in,
    input wire arst_n_in,
    input wire rx_valid_in,
    input wire [7:0] rx_byte_in,
    input wire tx_ready_in,
    output reg tx_valid_out,
    output reg [7:0] tx_byte_out,
    input wire [31:0] index_in,
    input wire [31:0] accu_in,
    output reg accu_we_out,
    output reg [31:0] accu_out,
    output reg par_we_out,
    output reg par_re_out,
    output reg [7:0] par_num_out,
    output reg [7:0] par_axis_out,
    output reg [31:0] par_wdata_out,
    input wire par_rvalid_in,
    input wire [31:0] par_rdata_in
);
    localparam ST_RX = 3'd0;
    localparam ST_EXEC = 3'd1;
    localparam ST_STOP2 = 3'd2;
    localparam ST_WAITRD = 3'd3;
    localparam ST_TX = 3'd4;
    localparam ST_VARRD = 3'd5;

    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] frm_r [0:7];
    reg [7:0] sum_r;
    reg [7:0] status_r;
    reg [31:0] rval_r;
    reg [31:0] vars_r [0:NUM_VARS-1];
    reg [7:0] vidx_r;
    reg [7:0] tsum_r;
    wire [31:0] fval = {frm_r[4], frm_r[5], frm_r[6], frm_r[7]};
    wire idx_ok = (index_in <= `IAXC_VAR_MAX);
    // reply byte k of the nine-byte answer
    function [7:0] reply_byte;
        input [3:0] k;
        input [7:0] st;
        input [7:0] op;
        input [31:0] v;
        input [7:0] cs;
        begin
            case (k)
                4'd0: reply_byte = HOST_ADDR;
                4'd1: reply_byte = MODULE_ADDR;
                4'd2: reply_byte = st;
                4'd3: reply_byte = op;
                4'd4: reply_byte = v[31:24];
                4'd5: reply_byte = v[23:16];
                4'd6: reply_byte = v[15:8];
                4'd7: reply_byte = v[7:0];
                default: reply_byte = cs;
            endcase
        end
    endfunction

    always @(posedge sys_clk_in)
    begin
        // user variables have no reset: software initialises them
        if (state_r == ST_EXEC && frm_r[1] == `IAXC_OP_VAR_STORE && idx_ok)
        begin
            vars_r[index_in[7:0]] <= fval;
        end
        else if (state_r == ST_EXEC && frm_r[1] == `IAXC_OP_VAR_FROM_ACCU && idx_ok)
        begin
            vars_r[index_in[7:0]] <= accu_in;
        end
    end

    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r <= ST_RX;
            cnt_r <= 4'h0;
            sum_r <= 8'h00;
            status_r <= 8'h00;
            rval_r <= 32'h0;
            vidx_r <= 8'h00;
            tsum_r <= 8'h00;
            tx_valid_out <= 1'b0;
            tx_byte_out <= 8'h00;
            accu_we_out <= 1'b0;
            accu_out <= 32'h0;
            par_we_out <= 1'b0;
            par_re_out <= 1'b0;
            par_num_out <= 8'h00;
            par_axis_out <= 8'h00;
            par_wdata_out <= 32'h0;
        end
        else
        begin
            accu_we_out <= 1'b0;
            par_we_out <= 1'b0;
            par_re_out <= 1'b0;
            case (state_r)
                ST_RX:
                begin
                    if (rx_valid_in)
                    begin
                        if (cnt_r == `IAXC_FRAME_LEN - 4'h1)
                        begin
                            cnt_r <= 4'h0;
                            sum_r <= 8'h00;
                            rval_r <= 32'h0;
                            if (rx_byte_in != sum_r)
                            begin
                                status_r <= `IAXC_ST_BAD_CSUM;
                                state_r <= ST_TX;
                            end
                            else if (frm_r[0] == MODULE_ADDR)
                            begin
                                state_r <= ST_EXEC;
                            end
                        end
                        else
                        begin
                            frm_r[cnt_r[2:0]] <= rx_byte_in;
                            sum_r <= sum_r + rx_byte_in;
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                ST_EXEC:
                begin
                    status_r <= `IAXC_ST_OK;
                    par_axis_out <= index_in[7:0];
                    par_num_out <= frm_r[2];
                    state_r <= ST_TX;
                    case (frm_r[1])
                        `IAXC_OP_SOFT_STOP:
                        begin
                            par_num_out <= `IAXC_PARAM_VEL_MODE;
                            par_wdata_out <= 32'h1;
                            par_we_out <= 1'b1;
                            state_r <= ST_STOP2;
                        end
                        `IAXC_OP_PARAM_WRITE:
                        begin
                            par_wdata_out <= fval;
                            par_we_out <= 1'b1;
                        end
                        `IAXC_OP_PARAM_READ:
                        begin
                            par_re_out <= 1'b1;
                            state_r <= ST_WAITRD;
                        end
                        `IAXC_OP_ACCU_TO_PARAM:
                        begin
                            par_wdata_out <= accu_in;
                            par_we_out <= 1'b1;
                        end
                        `IAXC_OP_VAR_STORE, `IAXC_OP_VAR_FROM_ACCU:
                        begin
                            status_r <= `IAXC_ST_OK;
                        end
                        `IAXC_OP_VAR_LOAD:
                        begin
                            vidx_r <= index_in[7:0];
                            if (idx_ok)
                            begin
                                state_r <= ST_VARRD;
                            end
                        end
                        default:
                        begin
                            status_r <= `IAXC_ST_BAD_CMD;
                        end
                    endcase
                end
                ST_STOP2:
                begin
                    par_num_out <= `IAXC_PARAM_TARGET_SPEED;
                    par_wdata_out <= 32'h0;
                    par_we_out <= 1'b1;
                    state_r <= ST_TX;
                end
                ST_WAITRD:
                begin
                    if (par_rvalid_in)
                    begin
                        accu_out <= par_rdata_in;
                        accu_we_out <= 1'b1;
                        rval_r <= par_rdata_in;
                        state_r <= ST_TX;
                    end
                end
                ST_VARRD:
                begin
                    accu_out <= vars_r[vidx_r];
                    accu_we_out <= 1'b1;
                    state_r <= ST_TX;
                end
                ST_TX:
                begin
                    // hold each byte until the sink takes it
                    if (!tx_valid_out || tx_ready_in)
                    begin
                        if (tx_valid_out && cnt_r == `IAXC_FRAME_LEN - 4'h1)
                        begin
                            tx_valid_out <= 1'b0;
                            cnt_r <= 4'h0;
                            tsum_r <= 8'h00;
                            state_r <= ST_RX;
                        end
                        else
                        begin
                            tx_valid_out <= 1'b1;
                            tx_byte_out <= reply_byte(cnt_r + (tx_valid_out ? 4'h1 : 4'h0),
                                status_r, frm_r[1], rval_r,
                                tsum_r + (tx_valid_out ? tx_byte_out : 8'h00));
                            tsum_r <= tsum_r + (tx_valid_out ? tx_byte_out : 8'h00);
                            cnt_r <= cnt_r + (tx_valid_out ? 4'h1 : 4'h0);
                        end
                    end
                end
                default:
                begin
                    state_r <= ST_RX;
                end
            endcase
        end
    end
endmodule // iaxc_exec
`default_nettype wire

// file: test/iaxc_exec_assertions.sv
// concurrent checks on the ports of the indexed axis command executor
`timescale 1ns/10ps
`default_nettype none
module iaxc_exec_assertions (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic tx_ready_in,
    input wire logic tx_valid_out,
    input wire logic [7:0] tx_byte_out,
    input wire logic [31:0] index_in,
    input wire logic accu_we_out,
    input wire logic [31:0] accu_out,
    input wire logic par_we_out,
    input wire logic par_re_out,
    input wire logic [7:0] par_num_out,
    input wire logic [7:0] par_axis_out,
    input wire logic [31:0] par_wdata_out,
    input wire logic par_rvalid_in,
    input wire logic [31:0] par_rdata_in
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    property p_axis; par_we_out || par_re_out |-> par_axis_out == index_in[7:0]; endproperty
    a_axis: assert property (p_axis) else $error("axis not from index");
    property p_stop; par_we_out && par_num_out == 8'hff |-> par_wdata_out == 32'h1
        ##1 (par_we_out && par_num_out == 8'h02 && par_wdata_out == 32'h0); endproperty
    a_stop: assert property (p_stop) else $error("soft stop sequence wrong");
    property p_rd; par_rvalid_in |-> ##[0:2] (accu_we_out && accu_out == par_rdata_in);
    endproperty
    a_rd: assert property (p_rd) else $error("read data not in accumulator");
    property p_first; $rose(tx_valid_out) |-> tx_byte_out == 8'h02; endproperty
    a_first: assert property (p_first) else $error("reply not opened by host addr");
    property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out);
    endproperty
    a_hold: assert property (p_hold) else $error("reply byte dropped");
    property p_re_one; par_re_out |=> !par_re_out; endproperty
    a_re_one: assert property (p_re_one) else $error("read strobe too long");
    property p_we_one; par_we_out && par_num_out != 8'hff |=> !par_we_out; endproperty
    a_we_one: assert property (p_we_one) else $error("write strobe too long");
    property p_quiet; tx_valid_out |-> !par_we_out && !par_re_out; endproperty
    a_quiet: assert property (p_quiet) else $error("access during reply");
    c_rd: cover property (par_re_out);
    c_acc: cover property (accu_we_out);
    c_tx: cover property (tx_valid_out && tx_ready_in);
endmodule // iaxc_exec_assertions
`default_nettype wire

// file: test/iaxc_host.sv
// host model: sends command frames, collects reply frames
`timescale 1ns/10ps
`default_nettype none
module iaxc_host (
    input wire logic clk_in,
    output logic rx_valid_out = 0,
    output logic [7:0] rx_byte_out = 8'h00,
    output logic tx_ready_out = 0,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_byte_in
);
    logic [7:0] rep [9];
    // bad is xored into the checksum to force a refusal
    task automatic send(input logic [63:0] f, input logic [7:0] bad);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk_in);
            #1 rx_valid_out = 1;
            rx_byte_out = i < 8 ? f[63-8*i -: 8] : s ^ bad;
            s = s + rx_byte_out;
        end
        @(posedge clk_in);
        #1 rx_valid_out = 0;
        rx_byte_out = ~rx_byte_out;
    endtask
    // random stalls so each reply byte has to stand
    task automatic recv(output int n);
        n = 0;
        for (int t = 0; t < 200 && n < 9; t++)
        begin
            @(posedge clk_in);
            if (tx_valid_in && tx_ready_out)
            begin
                rep[n] = tx_byte_in;
                n++;
            end
            #1 tx_ready_out = n < 9 && $urandom % 2 == 1;
        end
    endtask
endmodule // iaxc_host
`default_nettype wire

// file: test/indexed_axis_command_exec_test.sv
// self-checking bench for the indexed axis command executor
`timescale 1ns/10ps
`default_nettype none
`include "iaxc_regs.vh"
module indexed_axis_command_exec_test;
    logic clk = 0;
    logic rst_n = 0;
    logic rxv, txr, txv, awe, pwe, pre, prv = 0;
    logic [7:0] rxb, txb, pnum, pax, wn, wx;
    logic [31:0] idx = 0, acc_i = 0, acc_o, pwd, prd = 0, la, wd, v;
    int n_mismatch = 0;
    int checked = 0;
    int na = 0;
    int n, m;
    always #50 clk = ~clk;
    iaxc_exec DUT (.sys_clk_in(clk), .arst_n_in(rst_n), .rx_valid_in(rxv), .rx_byte_in(rxb),
        .tx_ready_in(txr), .tx_valid_out(txv), .tx_byte_out(txb), .index_in(idx),
        .accu_in(acc_i), .accu_we_out(awe), .accu_out(acc_o), .par_we_out(pwe),
        .par_re_out(pre), .par_num_out(pnum), .par_axis_out(pax), .par_wdata_out(pwd),
        .par_rvalid_in(prv), .par_rdata_in(prd));
    iaxc_host H (.clk_in(clk), .rx_valid_out(rxv), .rx_byte_out(rxb), .tx_ready_out(txr),
        .tx_valid_in(txv), .tx_byte_in(txb));
    always @(posedge clk)
    begin
        if (pwe)
            {wn, wx, wd} <= {pnum, pax, pwd};
        if (awe)
            {la, na} <= {acc_o, na + 1};
    end
    // read data comes two cycles late so the wait is exercised
    always @(posedge clk)
        if (pre)
        begin
            repeat (2) @(posedge clk);
            #1 prv = 1;
            @(posedge clk);
            #1 prv = 0;
        end
    // wide enough for number, axis and data compared in one go
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, ty, bad, st, input logic [31:0] x, rv);
        logic [7:0] s;
        H.send({8'h01, op, ty, 8'h5a, x}, bad);
        H.recv(n);
        chk("reply count", 9, n);
        if (n < 9)
            final_report();
        s = 8'h00;
        for (int i = 0; i < 8; i++)
            s += H.rep[i];
        chk("reply head", {8'h02, 8'h01, st, op}, {H.rep[0], H.rep[1], H.rep[2], H.rep[3]});
        chk("reply value", rv, {H.rep[4], H.rep[5], H.rep[6], H.rep[7]});
        chk("reply csum", s, H.rep[8]);
        $display("test %h done", op);
    endtask
    initial
    begin
        v = $urandom(32'h24d43bfe);
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        for (int k = 0; k < 4; k++)
        begin
            v = $urandom;
            idx = k * 85;
            run(`IAXC_OP_PARAM_WRITE, 8'h04, 0, 8'h64, v, 0);
            chk("param write", {8'h04, idx[7:0], v}, {wn, wx, wd});
            acc_i = $urandom;
            run(`IAXC_OP_ACCU_TO_PARAM, 8'h06, 0, 8'h64, v, 0);
            chk("accu to param", {8'h06, acc_i}, {wn, wd});
            prd = $urandom;
            run(`IAXC_OP_PARAM_READ, 8'h01, 0, 8'h64, 0, prd);
            chk("param read", prd, la);
            run(`IAXC_OP_SOFT_STOP, 8'h00, 0, 8'h64, 0, 0);
            chk("soft stop", {8'h02, idx[7:0], 32'h0}, {wn, wx, wd});
            run(`IAXC_OP_VAR_STORE, v[7:0], 0, 8'h64, v, 0);
            run(`IAXC_OP_VAR_LOAD, 8'h00, 0, 8'h64, 0, 0);
            chk("var load", v, la);
            idx = k[0] ? 32'hffffffff : 32'h100;
            m = na;
            run(`IAXC_OP_VAR_STORE, 8'h00, 0, 8'h64, ~v, 0);
            run(`IAXC_OP_VAR_LOAD, 8'h00, 0, 8'h64, 0, 0);
            chk("var out of range", m, na);
            // ffffffff and 100h alias indices 255 and 0 if the range check were missing
            idx = k * 85;
            run(`IAXC_OP_VAR_LOAD, 8'h00, 0, 8'h64, 0, 0);
            chk("var kept", v, la);
            acc_i = $urandom;
            run(`IAXC_OP_VAR_FROM_ACCU, 8'h00, 0, 8'h64, 0, 0);
            run(`IAXC_OP_VAR_LOAD, 8'h00, 0, 8'h64, 0, 0);
            chk("var from accu", acc_i, la);
            run(v[15:8], 8'h00, 8'h01 << k, 8'h01, v, 0);
            run(8'h7e, 8'h00, 0, 8'h02, 0, 0);
        end
        // second reset in mid-run: outputs drop, next frame still served
        @(posedge clk);
        #1 rst_n = 0;
        @(posedge clk);
        #1 chk("reset quiet", 0, {txv, pwe, pre, awe, txb});
        rst_n = 1;
        run(`IAXC_OP_PARAM_WRITE, 8'h05, 0, 8'h64, v, 0);
        chk("write after reset", {8'h05, idx[7:0], v}, {wn, wx, wd});
        final_report();
    end
endmodule // indexed_axis_command_exec_test
bind iaxc_exec iaxc_exec_assertions chk_i (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .tx_ready_in(tx_ready_in),
    .tx_valid_out(tx_valid_out),
    .tx_byte_out(tx_byte_out),
    .index_in(index_in),
    .accu_we_out(accu_we_out),
    .accu_out(accu_out),
    .par_we_out(par_we_out),
    .par_re_out(par_re_out),
    .par_num_out(par_num_out),
    .par_axis_out(par_axis_out),
    .par_wdata_out(par_wdata_out),
    .par_rvalid_in(par_rvalid_in),
    .par_rdata_in(par_rdata_in)
);
`default_nettype wire
